// ===== hdl/adccr_consts.vh
`ifndef ADCCR_CONSTS_VH
`define ADCCR_CONSTS_VH

// register byte offsets
`define ADCCR_OFF_CONTROL 8'h00
`define ADCCR_OFF_RES_HIGH 8'h04
`define ADCCR_OFF_RES_LOW 8'h08
`define ADCCR_OFF_FLAGS 8'h0c
`define ADCCR_OFF_CLKDIV 8'h10

// converter_control fields
`define ADCCR_BIT_JUSTIFY 7
`define ADCCR_BIT_VREF 6
`define ADCCR_BIT_CHAN_HI 4
`define ADCCR_BIT_CHAN_LO 2
`define ADCCR_BIT_GO 1
`define ADCCR_BIT_ENABLE 0

// flags register fields
`define ADCCR_BIT_DONE_FLAG 0
`define ADCCR_BIT_IRQ_EN 1

// reset values
`define ADCCR_RST_CONTROL 8'h00
`define ADCCR_RST_CLKDIV 8'h03
`define ADCCR_RST_RESULT 10'h000

// conversion timing in converter clock periods
`define ADCCR_TAD_PER_CONV 4'hb
`define ADCCR_RES_MSB 10'h200

// AHB encodings
`define ADCCR_HTRANS_NONSEQ 2'b10
`define ADCCR_HTRANS_SEQ 2'b11

`endif

// ===== hdl/adccr_sar.v
`timescale 1ns/1ps
`include "adccr_consts.vh"

module adccr_sar (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // control
   input wire tad_en_i,
   input wire start_i,
   input wire abort_i,
   input wire comp_i,
   // status and data
   output reg busy_o,
   output reg done_o,
   output reg [9:0] result_o,
   output wire [9:0] trial_o
);

   localparam ST_IDLE = 1'b0;
   localparam ST_CONV = 1'b1;

   reg [3:0] cnt;
   reg [9:0] code;
   reg [9:0] mask;

   // dac trial word: decided bits plus the bit under test
   assign trial_o = code | mask;

   always @(posedge clk_i) begin
      done_o <= 1'b0;
      if (rst_i || abort_i) begin
         // abort leaves the previous result untouched
         busy_o <= ST_IDLE;
         cnt <= 4'h0;
         code <= 10'h000;
         mask <= 10'h000;
      end else if (start_i) begin
         busy_o <= ST_CONV;
         cnt <= 4'h0;
         code <= 10'h000;
         mask <= 10'h000;
      end else begin
         case (busy_o)
            ST_IDLE: begin
               cnt <= 4'h0;
            end
            ST_CONV: begin
               if (tad_en_i) begin
                  cnt <= cnt + 4'h1;
                  if (cnt == 4'h0) begin
                     // first period: hold the sample, arm msb trial
                     mask <= `ADCCR_RES_MSB;
                  end else begin
                     // one bit per period, msb first
                     code <= comp_i ? (code | mask) : code;
                     mask <= mask >> 1;
                  end
                  if (cnt == `ADCCR_TAD_PER_CONV - 4'h1) begin
                     // 11 periods per conversion
                     busy_o <= ST_IDLE;
                     done_o <= 1'b1;
                     result_o <= comp_i ? (code | mask) : code;
                  end
               end
            end
            default: busy_o <= ST_IDLE;
         endcase
      end
      if (rst_i) begin
         result_o <= `ADCCR_RST_RESULT;
      end
   end

endmodule // adccr_sar

// ===== hdl/adccr_top.v
// Operation
// - completion seen by go bit reading zero or by done interrupt
// - control bit 7: one right justified, zero left justified
// - control bit 6: one external reference pin, zero supply rail
// - channel bits 4:2 pick inputs 0-3, comparator ref, 0.6V, 1.2V
// - writing one to bit 1 starts; reads one while converting
// - go bit cleared by hardware at completion; zero means idle
// - bit 0 enables converter; zero holds all converter logic idle
// - left justified: high register bits 7:0 hold result 9:2
// - left justified: low register bits 7:6 hold result 1:0, rest zero
// - right justified: high register bits 1:0 hold result 9:8, rest zero
// - right justified: low register bits 7:0 hold result 7:0
// - result is unsigned 10-bit code of 1024 steps
// - completion clears go, sets done flag, loads result registers
// - clearing go early aborts and keeps previous result
// - a conversion lasts 11 converter clock periods
`timescale 1ns/1ps
`include "adccr_consts.vh"

module adccr_top (
   // clock and reset
   input wire CLK_I,
   input wire RST_I,
   // AHB-Lite slave
   input wire HSEL_I,
   input wire [7:0] HADDR_I,
   input wire [1:0] HTRANS_I,
   input wire HWRITE_I,
   input wire [2:0] HSIZE_I,
   input wire [31:0] HWDATA_I,
   input wire HREADY_I,
   output reg [31:0] HRDATA_O,
   output wire HREADYOUT_O,
   output wire HRESP_O,
   // analog front end
   input wire COMP_I,
   output reg [9:0] DAC_O,
   output reg [2:0] CHANNEL_O,
   output reg VREF_EXT_O,
   output reg ANALOG_ON_O,
   output reg SAMPLE_O,
   // completion
   output reg DONE_FLAG_O,
   output reg DONE_IRQ_O
);

   // converter_control fields
   reg result_justify_select;
   reg positive_reference_select;
   reg [2:0] input_channel_select;
   reg converter_enable;
   // flags and divider
   reg conversion_done_flag;
   reg conversion_done_irq_enable;
   reg [7:0] clk_div;
   reg [7:0] div_cnt;
   reg tad_en;
   // terminal count of the divider, never below one
   wire [7:0] tad_top;
   // reset image of converter_control, sliced per field
   localparam [7:0] RST_CTRL = `ADCCR_RST_CONTROL;
   // stored result
   wire [9:0] result_bits;

   // bus pipeline
   reg wr_pend;
   reg rd_wait;
   reg [7:0] wr_addr;
   wire addr_phase;
   wire wr_ctrl;
   wire wr_flags;
   wire wr_div;
   wire [31:0] wd;

   // converter handshake
   wire busy;
   wire done;
   wire [9:0] trial;
   reg start;
   reg abort;

   // format one result register from the 10-bit code
   function [7:0] fmt_result;
      input right;
      input high;
      input [9:0] res;
      begin
         if (right) begin
            if (high) begin
               fmt_result = {6'h00, res[9:8]};
            end else begin
               fmt_result = res[7:0];
            end
         end else begin
            if (high) begin
               fmt_result = res[9:2];
            end else begin
               fmt_result = {res[1:0], 6'h00};
            end
         end
      end
   endfunction

   // read mux, unmapped and unused bits zero
   function [31:0] read_word;
      input [7:0] a;
      input [7:0] ctrl;
      input [7:0] hi;
      input [7:0] lo;
      input [7:0] flg;
      input [7:0] dv;
      begin
         case (a)
            `ADCCR_OFF_CONTROL: read_word = {24'h000000, ctrl};
            `ADCCR_OFF_RES_HIGH: read_word = {24'h000000, hi};
            `ADCCR_OFF_RES_LOW: read_word = {24'h000000, lo};
            `ADCCR_OFF_FLAGS: read_word = {24'h000000, flg};
            `ADCCR_OFF_CLKDIV: read_word = {24'h000000, dv};
            default: read_word = 32'h00000000;
         endcase
      end
   endfunction

   // bus slave: zero-wait writes, one wait state on reads
   assign addr_phase = HSEL_I && HREADY_I &&
                       ((HTRANS_I == `ADCCR_HTRANS_NONSEQ) ||
                        (HTRANS_I == `ADCCR_HTRANS_SEQ));
   assign HREADYOUT_O = ~rd_wait;
   assign HRESP_O = 1'b0;
   assign wd = HWDATA_I;
   assign wr_ctrl = wr_pend && (wr_addr == `ADCCR_OFF_CONTROL);
   assign wr_flags = wr_pend && (wr_addr == `ADCCR_OFF_FLAGS);
   assign wr_div = wr_pend && (wr_addr == `ADCCR_OFF_CLKDIV);

   always @(posedge CLK_I) begin
      if (RST_I) begin
         wr_pend <= 1'b0;
         rd_wait <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= addr_phase && HWRITE_I;
         rd_wait <= addr_phase && !HWRITE_I;
         if (addr_phase) begin
            wr_addr <= HADDR_I;
         end
      end
   end

   // read data loaded in the wait cycle, after any prior write landed
   always @(posedge CLK_I) begin
      if (RST_I) begin
         HRDATA_O <= 32'h00000000;
      end else if (rd_wait) begin
         HRDATA_O <= read_word(wr_addr,
            {result_justify_select, positive_reference_select, 1'b0,
             input_channel_select, busy, converter_enable},
            fmt_result(result_justify_select, 1'b1, result_bits),
            fmt_result(result_justify_select, 1'b0, result_bits),
            {6'h00, conversion_done_irq_enable, conversion_done_flag},
            clk_div);
      end
   end

   // control register; bit 5 has no storage
   always @(posedge CLK_I) begin
      if (RST_I) begin
         result_justify_select <= RST_CTRL[`ADCCR_BIT_JUSTIFY];
         positive_reference_select <= RST_CTRL[`ADCCR_BIT_VREF];
         input_channel_select <= RST_CTRL[`ADCCR_BIT_CHAN_HI:`ADCCR_BIT_CHAN_LO];
         converter_enable <= RST_CTRL[`ADCCR_BIT_ENABLE];
      end else if (wr_ctrl) begin
         result_justify_select <= wd[`ADCCR_BIT_JUSTIFY];
         positive_reference_select <= wd[`ADCCR_BIT_VREF];
         input_channel_select <= wd[`ADCCR_BIT_CHAN_HI:`ADCCR_BIT_CHAN_LO];
         converter_enable <= wd[`ADCCR_BIT_ENABLE];
      end
   end

   // start and abort decode from a control write; abort also held while the converter is disabled
   always @* begin
      start = 1'b0;
      abort = 1'b0;
      if (wr_ctrl) begin
         // start needs the converter already on and the new value on
         start = wd[`ADCCR_BIT_GO] && wd[`ADCCR_BIT_ENABLE] &&
                 converter_enable && !busy;
         // go written zero mid conversion aborts
         abort = busy && (!wd[`ADCCR_BIT_GO] || !wd[`ADCCR_BIT_ENABLE]);
      end
      if (!converter_enable) begin
         abort = 1'b1;
      end
   end

   // flags register: done flag is write-one-to-clear, set wins
   always @(posedge CLK_I) begin
      if (RST_I) begin
         conversion_done_flag <= 1'b0;
         conversion_done_irq_enable <= 1'b0;
      end else begin
         if (wr_flags) begin
            conversion_done_irq_enable <= wd[`ADCCR_BIT_IRQ_EN];
         end
         if (done) begin
            conversion_done_flag <= 1'b1;
         end else if (wr_flags && wd[`ADCCR_BIT_DONE_FLAG]) begin
            conversion_done_flag <= 1'b0;
         end
      end
   end

   // dac output is one flop behind the trial word, so a period of one clock
   // would let the comparator judge a stale level: two clocks at the least
   assign tad_top = (clk_div == 8'h00) ? 8'h01 : clk_div;

   // converter clock divider, stopped while disabled
   always @(posedge CLK_I) begin
      if (RST_I) begin
         clk_div <= `ADCCR_RST_CLKDIV;
         div_cnt <= 8'h00;
         tad_en <= 1'b0;
      end else begin
         if (wr_div) begin
            clk_div <= wd[7:0];
         end
         if (!converter_enable || start) begin
            div_cnt <= 8'h00;
            tad_en <= 1'b0;
         end else if (div_cnt == tad_top) begin
            div_cnt <= 8'h00;
            tad_en <= 1'b1;
         end else begin
            div_cnt <= div_cnt + 8'h01;
            tad_en <= 1'b0;
         end
      end
   end

   adccr_sar u_sar (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .tad_en_i(tad_en),
      .start_i(start),
      .abort_i(abort),
      .comp_i(COMP_I),
      .busy_o(busy),
      .done_o(done),
      .result_o(result_bits),
      .trial_o(trial)
   );

   // front end drive, all from flip-flops
   always @(posedge CLK_I) begin
      if (RST_I) begin
         DAC_O <= 10'h000;
         CHANNEL_O <= 3'h0;
         VREF_EXT_O <= 1'b0;
         ANALOG_ON_O <= 1'b0;
         SAMPLE_O <= 1'b0;
         DONE_FLAG_O <= 1'b0;
         DONE_IRQ_O <= 1'b0;
      end else begin
         DAC_O <= converter_enable ? trial : 10'h000;
         CHANNEL_O <= input_channel_select;
         VREF_EXT_O <= positive_reference_select;
         ANALOG_ON_O <= converter_enable;
         // acquisition runs while on and not converting
         SAMPLE_O <= converter_enable && !busy && !start;
         DONE_FLAG_O <= conversion_done_flag;
         DONE_IRQ_O <= conversion_done_flag && conversion_done_irq_enable;
      end
   end

endmodule // adccr_top

// ===== tb/adccr_analog.sv
`timescale 1ns/1ps
module adccr_analog (
   // analog side
   input logic [9:0] level_i,
   input logic [9:0] dac_i,
   input logic on_i,
   // comparator
   output logic comp_o
);
   // pin already analog with driver off; acquisition settles at once
   assign comp_o = on_i & (level_i >= dac_i);
endmodule // adccr_analog

// ===== tb/adccr_top_chk.sv
`timescale 1ns/1ps
module adccr_top_chk (
   // clock, reset and bus
   input wire CLK_I,
   input wire RST_I,
   input wire HSEL_I,
   input wire [1:0] HTRANS_I,
   input wire HWRITE_I,
   input wire HREADY_I,
   input wire [31:0] HRDATA_O,
   input wire HREADYOUT_O,
   input wire HRESP_O,
   // converter side
   input wire [9:0] DAC_O,
   input wire [2:0] CHANNEL_O,
   input wire VREF_EXT_O,
   input wire ANALOG_ON_O,
   input wire SAMPLE_O,
   input wire DONE_FLAG_O,
   input wire DONE_IRQ_O
);
   logic wr_ph;
   logic rd_ph;
   wire rd_go = HSEL_I & HREADY_I & HTRANS_I[1] & !HWRITE_I;
   // data phase trackers
   always @(posedge CLK_I) begin
      if (RST_I) begin
         wr_ph <= 1'b0;
         rd_ph <= 1'b0;
      end else if (HREADY_I) begin
         wr_ph <= HSEL_I & HTRANS_I[1] & HWRITE_I;
         rd_ph <= rd_go;
      end
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   a_read_wait: assert property (rd_go |=> !HREADYOUT_O ##1 HREADYOUT_O)
      else $error("read wait state wrong");
   a_rdata_upper: assert property (rd_ph && HREADYOUT_O |-> HRDATA_O[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_resp_okay: assert property (HRESP_O == 1'b0)
      else $error("response not okay");
   a_off_idle: assert property (!ANALOG_ON_O ##1 !ANALOG_ON_O |-> DAC_O == 10'h0 && !SAMPLE_O)
      else $error("converter active while off");
   a_flag_hold: assert property ($fell(DONE_FLAG_O) |-> $past(wr_ph) || $past(wr_ph, 2))
      else $error("done flag dropped without write");
   a_irq_gate: assert property (DONE_IRQ_O |-> DONE_FLAG_O)
      else $error("irq without flag");
   a_cfg_write: assert property ($changed({CHANNEL_O, VREF_EXT_O, ANALOG_ON_O}) |->
      $past(wr_ph) || $past(wr_ph, 2))
      else $error("config changed without write");
   a_conv_min: assert property ($fell(SAMPLE_O) && ANALOG_ON_O |=> !SAMPLE_O [*8])
      else $error("conversion too short");
endmodule // adccr_top_chk
bind adccr_top adccr_top_chk chk_u (.CLK_I(CLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I),
   .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
   .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .DAC_O(DAC_O), .CHANNEL_O(CHANNEL_O),
   .VREF_EXT_O(VREF_EXT_O), .ANALOG_ON_O(ANALOG_ON_O), .SAMPLE_O(SAMPLE_O),
   .DONE_FLAG_O(DONE_FLAG_O), .DONE_IRQ_O(DONE_IRQ_O));

// ===== tb/adccr_top_bench.sv
`timescale 1ns/1ps
`include "adccr_consts.vh"
module adccr_top_bench;
   localparam logic [7:0] ctl = `ADCCR_OFF_CONTROL;
   localparam logic [7:0] rh = `ADCCR_OFF_RES_HIGH;
   localparam logic [7:0] rl = `ADCCR_OFF_RES_LOW;
   localparam logic [7:0] fl = `ADCCR_OFF_FLAGS;
   logic CLK_I, RST_I, HSEL_I, HWRITE_I, HREADYOUT_O, HRESP_O, COMP_I;
   logic VREF_EXT_O, ANALOG_ON_O, SAMPLE_O, DONE_FLAG_O, DONE_IRQ_O;
   logic [7:0] HADDR_I;
   logic [1:0] HTRANS_I;
   logic [31:0] HWDATA_I, HRDATA_O, rd;
   logic [9:0] DAC_O, level;
   logic [2:0] CHANNEL_O;
   logic [33:0] r;
   int err_count, checks, n, i;
   // control, level, expected high, expected low
   logic [33:0] rows [8] = '{{8'h01, 10'h3ff, 8'hff, 8'hc0}, {8'h85, 10'h000, 8'h00, 8'h00},
      {8'h49, 10'h2a5, 8'ha9, 8'h40}, {8'hcd, 10'h200, 8'h02, 8'h00},
      {8'h11, 10'h155, 8'h55, 8'h40}, {8'h95, 10'h0ab, 8'h00, 8'hab},
      {8'h59, 10'h001, 8'h00, 8'h40}, {8'h9d, 10'h3c3, 8'h03, 8'hc3}};
   adccr_top dut_u (.CLK_I(CLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
      .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(3'h2), .HWDATA_I(HWDATA_I),
      .HREADY_I(HREADYOUT_O), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
      .HRESP_O(HRESP_O), .COMP_I(COMP_I), .DAC_O(DAC_O), .CHANNEL_O(CHANNEL_O),
      .VREF_EXT_O(VREF_EXT_O), .ANALOG_ON_O(ANALOG_ON_O), .SAMPLE_O(SAMPLE_O),
      .DONE_FLAG_O(DONE_FLAG_O), .DONE_IRQ_O(DONE_IRQ_O));
   adccr_analog model_u (.level_i(level), .dac_i(DAC_O), .on_i(ANALOG_ON_O), .comp_o(COMP_I));
   initial begin
      CLK_I = 1'b0;
      forever #10 CLK_I = ~CLK_I;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask
   task stop_test;
      $display("mismatches %0d of %0d checks", err_count, checks);
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // hold until hready is seen high at a rising edge
   task wt;
      int k;
      k = 0;
      @(negedge CLK_I);
      while (HREADYOUT_O !== 1'b1) begin
         k++;
         if (k > 20) begin
            err_count++;
            stop_test;
         end
         @(negedge CLK_I);
      end
      rd = HRDATA_O;
      @(posedge CLK_I);
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      HADDR_I <= a;
      HWRITE_I <= w;
      HTRANS_I <= `ADCCR_HTRANS_NONSEQ;
      wt;
      HTRANS_I <= 2'h0;
      HWDATA_I <= {24'h0, d};
      wt;
   endtask
   task rc(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(rd, {24'h0, e});
   endtask
   initial begin
      err_count = 0;
      checks = 0;
      RST_I = 1'b1;
      HSEL_I = 1'b1;
      HADDR_I = 8'h00;
      HTRANS_I = 2'h0;
      HWRITE_I = 1'b0;
      HWDATA_I = 32'h0;
      level = 10'h000;
      repeat (10) @(posedge CLK_I);
      RST_I <= 1'b0;
      @(posedge CLK_I);
      for (i = 0; i < 4; i++) rc(8'(4 * i), 8'h00);
      rc(`ADCCR_OFF_CLKDIV, 8'h03);
      bus(1'b1, 8'h14, 8'hff);
      rc(8'h14, 8'h00);
      bus(1'b1, rh, 8'hff);
      rc(rh, 8'h00);
      bus(1'b1, ctl, 8'hff);
      rc(ctl, 8'hdd);
      bus(1'b1, ctl, 8'h00);
      $display("test reset done");
      for (i = 0; i < 8; i++) begin
         r = rows[i];
         level <= r[25:16];
         bus(1'b1, ctl, r[33:26]);
         bus(1'b1, ctl, r[33:26] | 8'h02);
         rc(ctl, r[33:26] | 8'h02);
         n = 0;
         while (rd[1] && n < 100) begin
            bus(1'b0, ctl, 8'h00);
            n++;
         end
         if (n >= 100) begin
            err_count++;
            stop_test;
         end
         chk(rd, {24'h0, r[33:26]});
         chk({CHANNEL_O, VREF_EXT_O}, {r[30:28], r[32]});
         rc(rh, r[15:8]);
         rc(rl, r[7:0]);
         rc(fl, 8'h01);
         bus(1'b1, fl, 8'h01);
         $display("test row %0d done", i);
      end
      level <= 10'h000;
      bus(1'b1, ctl, 8'h81);
      bus(1'b1, ctl, 8'h83);
      for (i = 0; i < 4; i++) rc(ctl, 8'h83);
      bus(1'b1, ctl, 8'h81);
      for (i = 0; i < 8; i++) rc(ctl, 8'h81);
      rc(rh, 8'h03);
      rc(rl, 8'hc3);
      rc(fl, 8'h00);
      $display("test abort done");
      bus(1'b1, `ADCCR_OFF_CLKDIV, 8'h01);
      bus(1'b1, fl, 8'h02);
      level <= 10'h1e7;
      bus(1'b1, ctl, 8'h03);
      n = 0;
      while (DONE_FLAG_O !== 1'b1 && n < 40) begin
         @(negedge CLK_I);
         n++;
      end
      chk(n >= 22 && n <= 26, 1);
      chk(DONE_IRQ_O, 1);
      @(posedge CLK_I);
      rc(rh, 8'h79);
      rc(rl, 8'hc0);
      rc(fl, 8'h03);
      bus(1'b1, fl, 8'h03);
      rc(fl, 8'h02);
      chk(DONE_IRQ_O, 0);
      $display("test timing done");
      stop_test;
   end
endmodule // adccr_top_bench
